//--- rtl/vscr_pkg.sv
// Constants and types shared by the set-point clamp register bank
package vscr_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] VSCR_CMD_SETPOINT = 8'h21;
	localparam logic [7:0] VSCR_CMD_CEILING = 8'h24;
	localparam logic [7:0] VSCR_CMD_MARGIN_HI = 8'h25;

	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] VSCR_CEILING_RST = 8'hff;
	localparam logic [7:0] VSCR_MARGIN_RST = 8'h00;
	localparam logic [7:0] VSCR_RSVD_BYTE = 8'h00;
	localparam logic [7:0] VSCR_SETPOINT_RST = 8'h00;

	// Status bit positions
	localparam int VSCR_SB_OTHER = 0;
	localparam int VSCR_SW_VOUT = 15;
	localparam int VSCR_SV_MAX_WARN = 3;

	// Operation selections
	typedef enum logic [1:0] {
		VSCR_OP_NOMINAL = 2'b00,
		VSCR_OP_MARGIN_HI = 2'b01,
		VSCR_OP_MARGIN_LO = 2'b10
	} vscr_op_t;

	// Register selector shared with the storage module
	typedef enum logic [1:0] {
		VSCR_SEL_NONE = 2'b00,
		VSCR_SEL_SETPOINT = 2'b01,
		VSCR_SEL_CEILING = 2'b10,
		VSCR_SEL_MARGIN = 2'b11
	} vscr_sel_t;
endpackage : vscr_pkg

//--- rtl/vscr_store_if.sv
// Interface between the command decoder and the level storage
`timescale 1ns/1ps
interface vscr_store_if;
	import vscr_pkg::*;
	logic wr_en;
	vscr_sel_t wr_sel;
	logic [7:0] wr_data;
	logic [7:0] setpoint;
	logic [7:0] ceiling;
	logic [7:0] margin_hi;
	logic clamped;

	modport ctrl (
		output wr_en,
		output wr_sel,
		output wr_data,
		input setpoint,
		input ceiling,
		input margin_hi,
		input clamped
	);
	modport store (
		input wr_en,
		input wr_sel,
		input wr_data,
		output setpoint,
		output ceiling,
		output margin_hi,
		output clamped
	);
endinterface : vscr_store_if

//--- rtl/vscr_level_store.sv
// Level storage with ceiling clamp applied on set-point and ceiling writes
`timescale 1ns/1ps
module vscr_level_store (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Decoder side
	vscr_store_if.store st
);
	import vscr_pkg::*;

	logic [7:0] setpoint_q;
	logic [7:0] ceiling_q;
	logic [7:0] margin_q;
	logic clamped_q;

	assign st.setpoint = setpoint_q;
	assign st.ceiling = ceiling_q;
	assign st.margin_hi = margin_q;
	assign st.clamped = clamped_q;

	// A lowered ceiling also pulls an existing set-point down
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			setpoint_q <= VSCR_SETPOINT_RST;
		end else if (st.wr_en && st.wr_sel == VSCR_SEL_SETPOINT) begin
			if (st.wr_data > ceiling_q) begin
				setpoint_q <= ceiling_q; // see RULE_04
			end else begin
				setpoint_q <= st.wr_data;
			end
		end else if (st.wr_en && st.wr_sel == VSCR_SEL_CEILING &&
			setpoint_q > st.wr_data) begin
			setpoint_q <= st.wr_data; // see RULE_01
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ceiling_q <= VSCR_CEILING_RST; // see RULE_11
		end else if (st.wr_en && st.wr_sel == VSCR_SEL_CEILING) begin
			ceiling_q <= st.wr_data;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			margin_q <= VSCR_MARGIN_RST; // see RULE_13
		end else if (st.wr_en && st.wr_sel == VSCR_SEL_MARGIN) begin
			margin_q <= st.wr_data;
		end
	end

	// One-cycle pulse flagging an over-ceiling set-point request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clamped_q <= 1'b0;
		end else begin
			clamped_q <= st.wr_en && st.wr_sel == VSCR_SEL_SETPOINT &&
				st.wr_data > ceiling_q; // see RULE_03
		end
	end

	chk_ceiling_bound: assert property ( // see RULE_01
		@(posedge clk_i) disable iff (!rst_n_i)
		setpoint_q <= ceiling_q)
		else $error("set-point above ceiling");
endmodule : vscr_level_store

//--- rtl/vscr_regs.sv
// Set-point, ceiling and margin-high register bank with clamp warning
//
// Operation
// RULE_01 - Set-point readable, writable, never above ceiling
// RULE_02 - Ceiling bounds every commanded output level
// RULE_03 - Over-ceiling request is a warning, not fault
// RULE_04 - Over-ceiling request loads ceiling into set-point
// RULE_05 - Over-ceiling sets other bit in status byte
// RULE_06 - Over-ceiling sets output bit in status word
// RULE_07 - Over-ceiling sets max warning in output status
// RULE_08 - Over-ceiling request asserts the bus alert
// RULE_09 - Two bytes, code low, upper byte zero
// RULE_10 - VID protocol from strap or vendor setting
// RULE_11 - Ceiling readable, writable, resets to all ones
// RULE_12 - Margin-high operation drives margin-high level
// RULE_13 - Margin-high readable, writable, resets to zero
// RULE_14 - Set-point write moves the regulated output
// RULE_15 - Upper byte writes ignored, reads return zero
`timescale 1ns/1ps
module vscr_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Command port from the host interface logic
	input wire logic wr_i,
	input wire logic [7:0] cmd_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic hit_o,
	// Operation state and protocol selection
	input wire vscr_pkg::vscr_op_t op_sel_i,
	input wire logic slew_protocol_strap_i,
	input wire logic vendor_protocol_select_i,
	input wire logic vendor_override_i,
	// Status clear, one input shared by all status groups
	input wire logic clr_status_i,
	// Status and alert
	output logic [7:0] status_byte_o,
	output logic [15:0] status_word_o,
	output logic [7:0] status_vout_o,
	output logic alert_n_o,
	output logic shutdown_o,
	// Regulation target
	output logic [7:0] target_vid_o,
	output logic target_load_o,
	output logic vid_protocol_o
);
	import vscr_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	function automatic vscr_sel_t decode_cmd(input logic [7:0] cmd);
		vscr_sel_t sel;
		sel = VSCR_SEL_NONE;
		if (cmd == VSCR_CMD_SETPOINT) begin
			sel = VSCR_SEL_SETPOINT;
		end else if (cmd == VSCR_CMD_CEILING) begin
			sel = VSCR_SEL_CEILING;
		end else if (cmd == VSCR_CMD_MARGIN_HI) begin
			sel = VSCR_SEL_MARGIN;
		end
		return sel;
	endfunction : decode_cmd

	vscr_store_if st_if ();
	vscr_sel_t sel;
	assign sel = decode_cmd(cmd_i);
	assign hit_o = sel != VSCR_SEL_NONE;
	assign st_if.wr_en = wr_i && hit_o;
	assign st_if.wr_sel = sel;
	// Only the low byte is stored; the upper byte is dropped
	assign st_if.wr_data = wdata_i[7:0]; // see RULE_15

	vscr_level_store u_store (
		.clk_i(clk_i),
		.rst_n_i(rst_n_q),
		.st(st_if.store)
	);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [7:0] rd_low;
	always_comb begin
		rd_low = VSCR_RSVD_BYTE;
		case (sel)
			VSCR_SEL_SETPOINT: rd_low = st_if.setpoint;
			VSCR_SEL_CEILING: rd_low = st_if.ceiling;
			VSCR_SEL_MARGIN: rd_low = st_if.margin_hi;
			default: rd_low = VSCR_RSVD_BYTE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_o <= {VSCR_RSVD_BYTE, VSCR_RSVD_BYTE};
		end else begin
			rdata_o <= {VSCR_RSVD_BYTE, rd_low}; // see RULE_09
		end
	end

	// ------------------------------------------------------------
	// Warning status; set wins over a same-cycle clear
	// ------------------------------------------------------------
	logic other_q;
	logic vout_sum_q;
	logic max_warn_q;
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			other_q <= 1'b0;
		end else if (st_if.clamped) begin
			other_q <= 1'b1; // see RULE_05
		end else if (clr_status_i) begin
			other_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			vout_sum_q <= 1'b0;
		end else if (st_if.clamped) begin
			vout_sum_q <= 1'b1; // see RULE_06
		end else if (clr_status_i) begin
			vout_sum_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			max_warn_q <= 1'b0;
		end else if (st_if.clamped) begin
			max_warn_q <= 1'b1; // see RULE_07
		end else if (clr_status_i) begin
			max_warn_q <= 1'b0;
		end
	end

	always_comb begin
		status_byte_o = '0;
		status_byte_o[VSCR_SB_OTHER] = other_q;
		status_word_o = '0;
		status_word_o[VSCR_SW_VOUT] = vout_sum_q;
		status_word_o[7:0] = status_byte_o;
		status_vout_o = '0;
		status_vout_o[VSCR_SV_MAX_WARN] = max_warn_q;
	end

	// Alert follows any pending warning
	assign alert_n_o = !max_warn_q; // see RULE_08
	// A clamp is only a warning, so this block never shuts down
	assign shutdown_o = 1'b0; // see RULE_03

	// ------------------------------------------------------------
	// Regulation target
	// ------------------------------------------------------------
	logic [7:0] tgt_d;
	logic [7:0] tgt_q;
	always_comb begin
		tgt_d = st_if.setpoint;
		if (op_sel_i == VSCR_OP_MARGIN_HI) begin
			tgt_d = st_if.margin_hi; // see RULE_12
		end
		// Hard bound even in margin states
		if (tgt_d > st_if.ceiling) begin
			tgt_d = st_if.ceiling; // see RULE_02
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tgt_q <= VSCR_SETPOINT_RST;
		end else begin
			tgt_q <= tgt_d;
		end
	end
	assign target_vid_o = tgt_q;

	// Pulses when a new set-point write reaches the store, one cycle before the target
	logic load_q;
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			load_q <= 1'b0;
		end else begin
			load_q <= st_if.wr_en && sel == VSCR_SEL_SETPOINT; // see RULE_14
		end
	end
	assign target_load_o = load_q;

	logic proto_q;
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			proto_q <= 1'b0;
		end else if (vendor_override_i) begin
			proto_q <= vendor_protocol_select_i; // see RULE_10
		end else begin
			proto_q <= slew_protocol_strap_i; // see RULE_10
		end
	end
	assign vid_protocol_o = proto_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_target_bound: assert property ( // see RULE_02
		@(posedge clk_i) disable iff (!rst_n_q)
		target_vid_o <= st_if.ceiling || $past(wr_i))
		else $error("target above ceiling");
	chk_clamp_load: assert property ( // see RULE_04
		@(posedge clk_i) disable iff (!rst_n_q)
		wr_i && sel == VSCR_SEL_SETPOINT && wdata_i[7:0] > st_if.ceiling
		|=> st_if.setpoint == $past(st_if.ceiling))
		else $error("clamped set-point wrong");
	chk_warn_status: assert property ( // see RULE_05
		@(posedge clk_i) disable iff (!rst_n_q)
		st_if.clamped |=> status_byte_o[VSCR_SB_OTHER] &&
		status_word_o[VSCR_SW_VOUT])
		else $error("status summary not set");
	chk_warn_word: assert property ( // see RULE_06
		@(posedge clk_i) disable iff (!rst_n_q)
		st_if.clamped |=> status_word_o[VSCR_SW_VOUT])
		else $error("status word bit not set");
	chk_warn_vout: assert property ( // see RULE_07
		@(posedge clk_i) disable iff (!rst_n_q)
		st_if.clamped |=> status_vout_o[VSCR_SV_MAX_WARN])
		else $error("max warning not set");
	chk_alert_set: assert property ( // see RULE_08
		@(posedge clk_i) disable iff (!rst_n_q)
		st_if.clamped |=> !alert_n_o ##1 (!alert_n_o || $past(clr_status_i)))
		else $error("alert not asserted");
	chk_alert_clear: assert property ( // see RULE_08
		@(posedge clk_i) disable iff (!rst_n_q)
		clr_status_i && !st_if.clamped |=> alert_n_o)
		else $error("alert not released by clear");
	chk_no_shutdown: assert property ( // see RULE_03
		@(posedge clk_i) disable iff (!rst_n_q)
		st_if.clamped |-> ##[0:2] !shutdown_o)
		else $error("shutdown on warning");
	chk_upper_zero: assert property ( // see RULE_09
		@(posedge clk_i) disable iff (!rst_n_q)
		rdata_o[15:8] == VSCR_RSVD_BYTE)
		else $error("reserved byte nonzero");
	chk_unknown_read: assert property ( // see RULE_09
		@(posedge clk_i) disable iff (!rst_n_q)
		!hit_o |=> rdata_o == {VSCR_RSVD_BYTE, VSCR_RSVD_BYTE})
		else $error("unknown code read nonzero");
	chk_ceiling_write: assert property ( // see RULE_11
		@(posedge clk_i) disable iff (!rst_n_q)
		wr_i && sel == VSCR_SEL_CEILING
		|=> st_if.ceiling == $past(wdata_i[7:0]))
		else $error("ceiling write lost");
	chk_ceiling_read: assert property ( // see RULE_11
		@(posedge clk_i) disable iff (!rst_n_q)
		sel == VSCR_SEL_CEILING
		|=> rdata_o == {VSCR_RSVD_BYTE, $past(st_if.ceiling)})
		else $error("ceiling read wrong");
	chk_margin_write: assert property ( // see RULE_13
		@(posedge clk_i) disable iff (!rst_n_q)
		wr_i && sel == VSCR_SEL_MARGIN
		|=> st_if.margin_hi == $past(wdata_i[7:0]))
		else $error("margin write lost");
	chk_margin_read: assert property ( // see RULE_13
		@(posedge clk_i) disable iff (!rst_n_q)
		sel == VSCR_SEL_MARGIN
		|=> rdata_o == {VSCR_RSVD_BYTE, $past(st_if.margin_hi)})
		else $error("margin read wrong");
	chk_setpoint_write: assert property ( // see RULE_01
		@(posedge clk_i) disable iff (!rst_n_q)
		wr_i && sel == VSCR_SEL_SETPOINT && wdata_i[7:0] <= st_if.ceiling
		|=> st_if.setpoint == $past(wdata_i[7:0]))
		else $error("set-point write lost");
	chk_margin_drive: assert property ( // see RULE_12
		@(posedge clk_i) disable iff (!rst_n_q)
		op_sel_i == VSCR_OP_MARGIN_HI && st_if.margin_hi <= st_if.ceiling
		&& !wr_i |=> target_vid_o == $past(st_if.margin_hi))
		else $error("margin level not driven");
	chk_load_pulse: assert property ( // see RULE_14
		@(posedge clk_i) disable iff (!rst_n_q)
		wr_i && sel == VSCR_SEL_SETPOINT |=> target_load_o ##1
		(!target_load_o || $past(wr_i && sel == VSCR_SEL_SETPOINT)))
		else $error("load pulse missing");
	chk_proto_vendor: assert property ( // see RULE_10
		@(posedge clk_i) disable iff (!rst_n_q)
		vendor_override_i |=> vid_protocol_o == $past(vendor_protocol_select_i))
		else $error("vendor protocol not taken");
	chk_proto_strap: assert property ( // see RULE_10
		@(posedge clk_i) disable iff (!rst_n_q)
		!vendor_override_i |=> vid_protocol_o == $past(slew_protocol_strap_i))
		else $error("strap protocol not taken");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------
	cov_clamp: cover property (@(posedge clk_i) disable iff (!rst_n_q)
		st_if.clamped);
	cov_margin: cover property (@(posedge clk_i) disable iff (!rst_n_q)
		op_sel_i == VSCR_OP_MARGIN_HI ##1 target_vid_o == st_if.margin_hi);
	cov_clear: cover property (@(posedge clk_i) disable iff (!rst_n_q)
		!alert_n_o ##1 clr_status_i ##1 alert_n_o);
	cov_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_n_q)
		st_if.wr_en ##1 st_if.wr_en);
	cov_vendor_proto: cover property (@(posedge clk_i) disable iff (!rst_n_q)
		vendor_override_i ##1 vid_protocol_o != slew_protocol_strap_i);
endmodule : vscr_regs

//--- verification/vscr_host_model.sv
// Host model issuing set-point, ceiling and margin commands on the command port
`timescale 1ns/1ps
module vscr_host_model (
	// Clock
	input wire logic clk_i,
	// Answer from the register bank
	input wire logic [15:0] rdata_i,
	// Command port
	output logic wr_o,
	output logic [7:0] cmd_o,
	output logic [15:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		cmd_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// One whole word per command, code on the separate command byte
	task automatic write(input logic [7:0] c, input logic [15:0] w);
		@(posedge clk_i);
		#1;
		wr_o = 1'b1;
		cmd_o = c;
		wdata_o = w;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		// Released data shows garbage, not the last word
		wdata_o = ~w;
	endtask : write
	// Two writes on consecutive edges, strobe held high between them
	task automatic write_pair(input logic [7:0] c0, input logic [15:0] w0,
		input logic [7:0] c1, input logic [15:0] w1);
		@(posedge clk_i);
		#1;
		wr_o = 1'b1;
		cmd_o = c0;
		wdata_o = w0;
		@(posedge clk_i);
		#1;
		cmd_o = c1;
		wdata_o = w1;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		wdata_o = ~w1;
	endtask : write_pair
	task automatic read(input logic [7:0] c, output logic [15:0] d);
		@(posedge clk_i);
		#1;
		cmd_o = c;
		@(posedge clk_i);
		#1;
		d = rdata_i;
	endtask : read
endmodule : vscr_host_model

//--- verification/test_vscr_regs.sv
// Self-checking bench for the set-point clamp register bank
`timescale 1ns/1ps
module test_vscr_regs;
	import vscr_pkg::*;
	typedef struct {
		logic [7:0] cmd;
		logic [15:0] wd;
		logic [15:0] rd;
		logic warn;
	} vscr_tb_row_t;
	logic clk_i, reset_n_i, wr_i, hit_o, alert_n_o, shutdown_o;
	logic strap, vendor, override, clr_status_i, target_load_o, vid_prot;
	logic [7:0] cmd_i, status_byte_o, status_vout_o, target_vid_o, sp;
	logic [15:0] wdata_i, rdata_o, status_word_o, d;
	vscr_op_t op_sel;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_load;
	// ------------------------------------------------------------
	// Ordinary cases, applied in order on cumulative state
	// ------------------------------------------------------------
	vscr_tb_row_t rows [8] = '{
		'{VSCR_CMD_CEILING, 16'hab40, 16'h0040, 1'b0},
		'{VSCR_CMD_SETPOINT, 16'h1230, 16'h0030, 1'b0},
		'{VSCR_CMD_SETPOINT, 16'h0040, 16'h0040, 1'b0},
		'{VSCR_CMD_SETPOINT, 16'h0041, 16'h0040, 1'b1},
		'{VSCR_CMD_SETPOINT, 16'hff80, 16'h0040, 1'b1},
		'{VSCR_CMD_MARGIN_HI, 16'hff55, 16'h0055, 1'b0},
		'{VSCR_CMD_CEILING, 16'h00ff, 16'h00ff, 1'b0},
		'{VSCR_CMD_SETPOINT, 16'h00ff, 16'h00ff, 1'b0}};

	vscr_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_i),
		.cmd_i(cmd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
		.op_sel_i(op_sel), .slew_protocol_strap_i(strap),
		.vendor_protocol_select_i(vendor), .vendor_override_i(override),
		.clr_status_i(clr_status_i), .status_byte_o(status_byte_o),
		.status_word_o(status_word_o), .status_vout_o(status_vout_o),
		.alert_n_o(alert_n_o), .shutdown_o(shutdown_o),
		.target_vid_o(target_vid_o), .target_load_o(target_load_o),
		.vid_protocol_o(vid_prot));
	vscr_host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .wr_o(wr_i),
		.cmd_o(cmd_i), .wdata_o(wdata_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: word %h not %h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: byte %h not %h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: bit %b not %b", $time, got, exp);
		end
	endtask : cmp_bit
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wait_cycles
	task automatic check_flags(input logic w);
		cmp_bit(status_byte_o[VSCR_SB_OTHER], w);
		cmp_bit(status_word_o[VSCR_SW_VOUT], w);
		cmp_bit(status_vout_o[VSCR_SV_MAX_WARN], w);
		cmp_bit(alert_n_o, ~w);
		cmp_bit(shutdown_o, 1'b0);
	endtask : check_flags
	task automatic clear_status();
		wait_cycles(1);
		clr_status_i = 1'b1;
		wait_cycles(1);
		clr_status_i = 1'b0;
		wait_cycles(1);
		check_flags(1'b0);
	endtask : clear_status
	task automatic do_reset();
		reset_n_i = 1'b0;
		wait_cycles(5);
		reset_n_i = 1'b1;
		// Internal release takes two edges
		wait_cycles(3);
	endtask : do_reset
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		{strap, vendor, override, clr_status_i} = 4'h0;
		op_sel = VSCR_OP_NOMINAL;
		sp = VSCR_SETPOINT_RST;
		do_reset();
		foreach (rows[i]) begin
			host.write(rows[i].cmd, rows[i].wd);
			n_load = 0;
			repeat (3) begin
				if (target_load_o === 1'b1)
					n_load++;
				@(posedge clk_i);
				#1;
			end
			if (rows[i].cmd == VSCR_CMD_SETPOINT)
				sp = rows[i].rd[7:0];
			cmp_bit(n_load == 1, rows[i].cmd == VSCR_CMD_SETPOINT);
			cmp_byte(target_vid_o, sp);
			check_flags(rows[i].warn);
			host.read(rows[i].cmd, d);
			cmp_word(d, rows[i].rd);
			cmp_bit(hit_o, 1'b1);
			clear_status();
		end
		$display("test table done");
		host.write_pair(VSCR_CMD_CEILING, 16'h0020, VSCR_CMD_SETPOINT, 16'h0090);
		wait_cycles(3);
		check_flags(1'b1);
		host.read(VSCR_CMD_SETPOINT, d);
		cmp_word(d, 16'h0020);
		clear_status();
		$display("test back to back done");
		host.write(VSCR_CMD_MARGIN_HI, 16'h0018);
		op_sel = VSCR_OP_MARGIN_HI;
		wait_cycles(3);
		cmp_byte(target_vid_o, 8'h18);
		host.write(VSCR_CMD_MARGIN_HI, 16'h0070);
		wait_cycles(3);
		cmp_byte(target_vid_o, 8'h20);
		op_sel = VSCR_OP_NOMINAL;
		wait_cycles(3);
		cmp_byte(target_vid_o, 8'h20);
		clear_status();
		$display("test margin done");
		host.read(8'h26, d);
		cmp_word(d, 16'h0000);
		cmp_bit(hit_o, 1'b0);
		for (int i = 0; i < 8; i++) begin
			{override, vendor, strap} = i[2:0];
			wait_cycles(2);
			cmp_bit(vid_prot, i[2] ? i[1] : i[0]);
		end
		$display("test protocol done");
		do_reset();
		check_flags(1'b0);
		host.read(VSCR_CMD_CEILING, d);
		cmp_word(d, 16'h00ff);
		host.read(VSCR_CMD_MARGIN_HI, d);
		cmp_word(d, 16'h0000);
		host.read(VSCR_CMD_SETPOINT, d);
		cmp_word(d, 16'h0000);
		$display("test reset done");
		report_and_stop();
	end
endmodule : test_vscr_regs
